// ### rtl/rpc_ctrl.sv
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`include "rpc_map.svh"
module rpc_ctrl #(
	parameter int WAKE_CYCLES = `RPC_WAKE_CYCLES
) (
	input  wire logic               i_clock,
	input  wire logic               i_rst,
	input  wire rpc_pkg::rpc_addr_t i_addr,
	input  wire rpc_pkg::rpc_data_t i_wdata,
	input  wire logic               i_wr,
	input  wire logic               i_rd,
	output rpc_pkg::rpc_data_t      o_rdata,
	input  wire logic               i_uart_powered,
	input  wire logic               i_line_valid,
	output logic                    o_power_kill_low,
	output logic                    o_auto_sleep_inhibit,
	output logic                    o_rx_gate_n,
	output logic                    o_uart_power_req
);
	import rpc_pkg::*;

	// ==========================================================
	// timing
	localparam int WAKE_W = 24;
	localparam logic [WAKE_W-1:0] WAKE_LAST = WAKE_W'(WAKE_CYCLES - 1);

	// ==========================================================
	// pin synchronisers
	logic line_valid_s;
	logic uart_powered_s;

	rpc_sync u_sync_valid (
		.i_clock (i_clock),
		.i_rst   (i_rst),
		.i_async (i_line_valid),
		.o_sync  (line_valid_s)
	);

	rpc_sync u_sync_uart (
		.i_clock (i_clock),
		.i_rst   (i_rst),
		.i_async (i_uart_powered),
		.o_sync  (uart_powered_s)
	);

	// ==========================================================
	// control register
	logic [7:0] ctrl_q;
	logic       run;
	logic       inhibit;
	logic       auto_off;

	assign run      = ctrl_q[`RPC_CTRL_RUN_BIT];
	assign inhibit  = ctrl_q[`RPC_CTRL_INHIBIT_BIT];
	assign auto_off = ctrl_q[`RPC_CTRL_AUTO_OFF_BIT];

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			ctrl_q <= `RPC_CTRL_RESET;
		end else if (i_wr && i_addr == `RPC_ADDR_CTRL) begin
			ctrl_q <= i_wdata;
		end
	end

	// ==========================================================
	// pin drive
	// manual control drives only the kill pin; inhibit follows the
	// register so auto power-down stays armed until software sets inhibit
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_power_kill_low     <= 1'b0;
			o_auto_sleep_inhibit <= 1'b0;
		end else begin
			o_power_kill_low     <= run;
			o_auto_sleep_inhibit <= inhibit;
		end
	end

	// receivers gated whenever the UART is unpowered
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_rx_gate_n <= 1'b1;
		end else begin
			o_rx_gate_n <= !uart_powered_s;
		end
	end

	// ==========================================================
	// link-up tracking from the activity flag
	rpc_state_t        state_q;
	logic [WAKE_W-1:0] wait_q;
	logic              seen_q;
	logic              lost_q;
	logic              valid_d1_q;

	// after a flag rise the device needs its wake latency before
	// transmitters are usable; track that so software knows
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			state_q <= RPC_OFF;
			wait_q  <= '0;
		end else begin
			case (state_q)
			RPC_OFF: begin
				wait_q <= '0;
				if (line_valid_s) begin
					state_q <= RPC_WAKING;
				end
			end
			RPC_WAKING: begin
				if (!line_valid_s) begin
					state_q <= RPC_OFF;
				end else if (wait_q == WAKE_LAST) begin
					state_q <= RPC_ON;
				end else begin
					wait_q <= wait_q + 1'b1;
				end
			end
			RPC_ON: begin
				if (!line_valid_s) begin
					state_q <= RPC_DRAIN;
				end
			end
			RPC_DRAIN: begin
				state_q <= RPC_OFF;
			end
			default: begin
				state_q <= RPC_OFF;
			end
			endcase
		end
	end

	// request UART power when line is up; auto_off lets it drop
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_uart_power_req <= 1'b0;
		end else begin
			o_uart_power_req <= line_valid_s || !auto_off;
		end
	end

	// sticky edges; a new edge wins over a status read clear
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			valid_d1_q <= 1'b0;
			seen_q     <= 1'b0;
			lost_q     <= 1'b0;
		end else begin
			valid_d1_q <= line_valid_s;
			if (line_valid_s && !valid_d1_q) begin
				seen_q <= 1'b1;
			end else if (i_rd && i_addr == `RPC_ADDR_STATUS) begin
				seen_q <= 1'b0;
			end
			if (!line_valid_s && valid_d1_q) begin
				lost_q <= 1'b1;
			end else if (i_rd && i_addr == `RPC_ADDR_STATUS) begin
				lost_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// read port
	function automatic rpc_data_t status_word(logic on, logic kill,
			logic gate, logic seen, logic lost);
		rpc_data_t w;
		w = '0;
		w[`RPC_STAT_ACTIVE_BIT] = on;
		w[`RPC_STAT_KILL_BIT]   = kill;
		w[`RPC_STAT_GATE_BIT]   = gate;
		w[`RPC_STAT_SEEN_BIT]   = seen;
		w[`RPC_STAT_LOST_BIT]   = lost;
		return w;
	endfunction

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_rdata <= '0;
		end else if (i_rd) begin
			case (i_addr)
			`RPC_ADDR_CTRL:     o_rdata <= ctrl_q;
			`RPC_ADDR_STATUS:   o_rdata <= status_word(
				state_q == RPC_ON, o_power_kill_low, o_rx_gate_n,
				seen_q, lost_q);
			`RPC_ADDR_WAKE_CNT: o_rdata <= wait_q[7:0];
			default:            o_rdata <= '0;
			endcase
		end else begin
			o_rdata <= '0;
		end
	end

	// ==========================================================
	// checks
	a_gate_follows_uart: assert property (@(posedge i_clock)
		disable iff (i_rst) !uart_powered_s |=> o_rx_gate_n)
		else $error("receiver gate not raised for idle uart");
	a_kill_follows_run: assert property (@(posedge i_clock)
		disable iff (i_rst) $rose(run) |=> o_power_kill_low)
		else $error("kill pin not released after run");
	a_inhibit_follows: assert property (@(posedge i_clock)
		disable iff (i_rst) inhibit |=> o_auto_sleep_inhibit)
		else $error("inhibit pin not driven");
	a_wake_no_early: assert property (@(posedge i_clock)
		disable iff (i_rst) $rose(state_q == RPC_WAKING) |->
		##1 (state_q != RPC_ON))
		else $error("link reported up too early");
	a_drop_to_off: assert property (@(posedge i_clock)
		disable iff (i_rst) (state_q == RPC_ON && !line_valid_s) |=>
		##1 state_q == RPC_OFF)
		else $error("loss of line not tracked");
endmodule

// ### rtl/rpc_map.svh
`ifndef RPC_MAP_SVH
`define RPC_MAP_SVH
// register offsets of the controller's own register file
`define RPC_ADDR_CTRL        4'h0
`define RPC_ADDR_STATUS      4'h1
`define RPC_ADDR_WAKE_CNT    4'h2
// control register fields
`define RPC_CTRL_RUN_BIT     0
`define RPC_CTRL_INHIBIT_BIT 1
`define RPC_CTRL_AUTO_OFF_BIT 2
`define RPC_CTRL_RESET       8'h00
// status register fields
`define RPC_STAT_ACTIVE_BIT  0
`define RPC_STAT_KILL_BIT    1
`define RPC_STAT_GATE_BIT    2
`define RPC_STAT_SEEN_BIT    3
`define RPC_STAT_LOST_BIT    4
// timing, in ns, and the clock period
`define RPC_CLK_PERIOD_NS    25
`define RPC_WAKE_NS          100000
`define RPC_INVALID_NS       30000
`define RPC_WAKE_CYCLES      ((`RPC_WAKE_NS + `RPC_CLK_PERIOD_NS - 1) / `RPC_CLK_PERIOD_NS)
`define RPC_INVALID_CYCLES   ((`RPC_INVALID_NS + `RPC_CLK_PERIOD_NS - 1) / `RPC_CLK_PERIOD_NS)
`endif

// ### rtl/rpc_pkg.sv
package rpc_pkg;
	typedef enum logic [3:0] {
		RPC_OFF    = 4'b0001,
		RPC_WAKING = 4'b0010,
		RPC_ON     = 4'b0100,
		RPC_DRAIN  = 4'b1000
	} rpc_state_t;
	typedef logic [3:0] rpc_addr_t;
	typedef logic [7:0] rpc_data_t;
endpackage

// ### rtl/rpc_sync.sv
`timescale 1ns/1ps
module rpc_sync (
	input  wire logic i_clock,
	input  wire logic i_rst,
	input  wire logic i_async,
	output logic      o_sync
);
	logic meta_q;
	// meta_q feeds only the second stage
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			meta_q <= 1'b0;
			o_sync <= 1'b0;
		end else begin
			meta_q <= i_async;
			o_sync <= meta_q;
		end
	end
endmodule

// ### tb/rpc_dev_model.sv
`timescale 1ns/1ps
// ====
// far-side transceiver: flag timing and power state
module rpc_dev_model #(
	parameter int INV_CYC   = 12,
	parameter int RISE_CYC  = 2,
	parameter int RAIL_FULL = 4
) (
	input  wire logic i_clock,
	input  wire logic i_power_kill_low,
	input  wire logic i_auto_sleep_inhibit,
	input  wire logic i_rx_gate_n,
	input  wire logic i_levels,
	input  wire logic i_tx_data,
	input  wire logic i_rx_line_pos,
	output logic      o_line_valid,
	output logic      o_tx_on,
	output logic      o_rx_drive,
	output logic      o_tx_line_pos,
	output logic      o_rx_data,
	output logic      o_pump_on
);
	int   inv_n   = 0;
	int   val_n   = 0;
	int   rail_n  = 0;
	logic valid_q = 1'b0;
	always @(posedge i_clock) begin
		inv_n <= i_levels ? 0 : inv_n + 1;
		val_n <= i_levels ? val_n + 1 : 0;
		if (!i_levels && inv_n >= INV_CYC)
			valid_q <= 1'b0;
		else if (i_levels && val_n >= RISE_CYC)
			valid_q <= 1'b1;
	end
	assign o_line_valid = valid_q;
	// with kill high and inhibit low, power state tracks the flag, so wake latency is the flag rise
	assign o_tx_on = i_power_kill_low &&
		(i_auto_sleep_inhibit || valid_q);
	// pump stops once the rails are full and restarts as they sag
	always @(posedge i_clock) begin
		if (!o_tx_on)
			rail_n <= 0;
		else if (o_pump_on)
			rail_n <= rail_n + 2;
		else
			rail_n <= rail_n - 1;
	end
	assign o_pump_on  = o_tx_on && rail_n < RAIL_FULL;
	assign o_rx_drive = !i_rx_gate_n;
	// inverting stages; line side only meaningful while enabled
	assign o_tx_line_pos = !i_tx_data;
	assign o_rx_data     = !i_rx_line_pos;
endmodule

// ### tb/rs232_power_down_control_tb_top.sv
`timescale 1ns/1ps
`include "rpc_map.svh"
module rs232_power_down_control_tb_top;
	import rpc_pkg::*;
	// wake time against invalid time keeps the device's 100:30 ratio
	localparam int WAKE = 40;
	localparam int INV  = 12;
	logic      clk = 1'b0;
	logic      rst = 1'b1;
	rpc_addr_t addr = 4'h0;
	rpc_data_t wdata = 8'h00;
	logic      wr_s = 1'b0;
	logic      rd_s = 1'b0;
	logic      upow = 1'b0;
	logic      lev = 1'b0;
	rpc_data_t rdata;
	rpc_data_t v;
	logic      lv, kl, inh, gn, req, ton;
	int        fails = 0;
	int        compares = 0;
	logic [5:0] rows [8] = '{6'h01, 6'h0D, 6'h13, 6'h1F,
		6'h20, 6'h2C, 6'h32, 6'h3E};
	rpc_ctrl #(.WAKE_CYCLES(WAKE)) dut (.i_clock(clk), .i_rst(rst),
		.i_addr(addr), .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s),
		.o_rdata(rdata), .i_uart_powered(upow), .i_line_valid(lv),
		.o_power_kill_low(kl), .o_auto_sleep_inhibit(inh),
		.o_rx_gate_n(gn), .o_uart_power_req(req));
	rpc_dev_model #(.INV_CYC(INV), .RISE_CYC(2)) dev (.i_clock(clk),
		.i_power_kill_low(kl), .i_auto_sleep_inhibit(inh),
		.i_rx_gate_n(gn), .i_levels(lev), .i_tx_data(1'b0),
		.i_rx_line_pos(lev), .o_line_valid(lv), .o_tx_on(ton),
		.o_rx_drive(), .o_tx_line_pos(), .o_rx_data(), .o_pump_on());
	initial forever #12.5 clk = ~clk;
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		compares++;
		if (s !== e) begin
			fails++;
			$display("ERROR %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic wr(input rpc_addr_t a, input rpc_data_t d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input rpc_addr_t a, output rpc_data_t d);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic report_and_stop();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// ====
	// sequence: table rows, then gate, line, reset cases
	initial begin
		wt(16);
		chk({4'h0, kl, inh, gn, req}, 8'h02);
		@(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			wr(`RPC_ADDR_CTRL, {5'h00, rows[i][5:3]});
			wt(3);
			chk({5'h00, kl, inh, req}, {5'h00, rows[i][2:0]});
			rd(`RPC_ADDR_STATUS, v);
			chk(v & 8'h02, {6'h00, rows[i][2], 1'b0});
		end
		@(posedge clk);
		upow <= 1'b1;
		wt(4);
		chk({7'h00, gn}, 8'h00);
		@(posedge clk);
		upow <= 1'b0;
		wt(4);
		chk({7'h00, gn}, 8'h01);
		wr(`RPC_ADDR_CTRL, 8'h05);
		@(posedge clk);
		lev <= 1'b1;
		wt(WAKE + 10);
		chk({6'h00, ton, req}, 8'h03);
		rd(`RPC_ADDR_STATUS, v);
		chk(v, 8'h0F);
		rd(`RPC_ADDR_STATUS, v);
		chk(v & 8'h08, 8'h00);
		@(posedge clk);
		lev <= 1'b0;
		wt(5);
		chk({7'h00, req}, 8'h01);
		wt(20);
		chk({6'h00, ton, req}, 8'h00);
		rd(`RPC_ADDR_STATUS, v);
		chk(v & 8'h11, 8'h10);
		// short burst: the flag falls again before the wake time ends
		@(posedge clk);
		lev <= 1'b1;
		wt(2);
		@(posedge clk);
		lev <= 1'b0;
		wt(26);
		rd(`RPC_ADDR_WAKE_CNT, v);
		chk(v, 8'h00);
		wt(14);
		rd(`RPC_ADDR_STATUS, v);
		chk(v & 8'h19, 8'h18);
		wr(`RPC_ADDR_CTRL, 8'h04);
		@(posedge clk);
		lev <= 1'b1;
		wt(WAKE + 4);
		rd(`RPC_ADDR_STATUS, v);
		chk(v & 8'h01, 8'h00);
		rd(`RPC_ADDR_STATUS, v);
		chk(v & 8'h01, 8'h01);
		chk({5'h00, ton, kl, req}, 8'h01);
		rd(`RPC_ADDR_WAKE_CNT, v);
		chk(v, 8'(WAKE - 1));
		rd(`RPC_ADDR_CTRL, v);
		chk(v, 8'h04);
		wr(4'hF, 8'hFF);
		wt(3);
		chk({6'h00, kl, inh}, 8'h00);
		rd(4'hF, v);
		chk(v, 8'h00);
		@(posedge clk);
		rst <= 1'b1;
		wt(2);
		chk({4'h0, kl, inh, gn, req}, 8'h02);
		report_and_stop();
	end
	initial begin
		#2000000;
		fails++;
		report_and_stop();
	end
endmodule
